// [core/cis_sequencer.sv]
// interrupt, stack and program counter sequencer of the 8-bit core
`timescale 1ns/10ps
`default_nettype none
module cis_sequencer
    import cis_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic int_reset_req,
    input wire logic cmd_valid,
    input wire cis_cmd_t cmd,
    input wire logic [15:0] target_addr,
    input wire logic instr_done,
    input wire logic ext_req_set,
    input wire logic capture_flag,
    input wire logic compare_flag,
    input wire logic overflow_flag,
    input wire logic capture_int_enable,
    input wire logic compare_int_enable,
    input wire logic overflow_int_enable,
    input wire logic alu_valid,
    input wire cis_alu_t alu_op,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    input wire logic alu_cbit,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] idx_in,
    input wire cis_idx_t idx_mode,
    input wire logic [15:0] idx_offset,
    input wire logic [7:0] mem_rdata,
    output logic busy_reg,
    output logic [15:0] prog_addr,
    output logic [7:0] condition_flags_register,
    output logic [7:0] stack_addr,
    output logic [15:0] mem_addr_reg,
    output logic [7:0] mem_wdata_reg,
    output logic mem_we_reg,
    output logic mem_re_reg,
    output cis_region_t mem_region_reg,
    output logic [7:0] alu_result_reg,
    output logic [15:0] eff_addr_reg,
    output logic restore_valid_reg,
    output logic [7:0] acc_out_reg,
    output logic [7:0] idx_out_reg,
    output logic ext_pending_reg
);

    cis_state_t state_reg, state_next;
    cis_kind_t kind_reg;
    logic [PC_W-1:0] pc_reg;
    logic [5:0] sp_reg;
    logic [4:0] flags_reg;
    logic [2:0] cnt_reg;
    logic [1:0] wait_reg;
    logic [15:0] vec_reg;
    logic [15:0] target_reg;
    logic [39:0] push_reg;
    logic [39:0] rd_reg;
    logic re_q1_reg;
    logic [5:0] sp_inc;
    logic timer_req, hw_pending, take_hw, cmd_ok, push_last, apply;
    logic start_swi, start_call, start_rti, start_rts;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_we, bus_re;
    logic [7:0] alu_res;
    logic alu_c, alu_h, upd_h, upd_c, upd_nz;
    logic [8:0] sum9;
    logic [4:0] half5;
    logic cin;
    cis_map_if map_bus ();

    cis_addr_map u_map (
        .map(map_bus.decoder)
    );

    assign prog_addr = {PC_UPPER, pc_reg};
    assign condition_flags_register = {CCR_ONES, flags_reg};
    assign stack_addr = {STACK_PAGE[1:0], sp_reg};
    assign sp_inc = sp_reg + 6'h01;

    // one merged timer request; the handler reads the individual flags
    assign timer_req = (capture_flag & capture_int_enable)
                     | (compare_flag & compare_int_enable)
                     | (overflow_flag & overflow_int_enable);
    assign hw_pending = ext_pending_reg | timer_req;
    // checked only when the core reports the instruction finished
    assign take_hw = (state_reg == S_IDLE) && instr_done
                   && !flags_reg[CCR_I] && hw_pending;
    // any command is refused, not held, in the cycle a hardware request is taken at the boundary
    assign cmd_ok = (state_reg == S_IDLE) && cmd_valid && !take_hw;
    assign start_swi = cmd_ok && (cmd == CMD_SWI);
    assign start_call = cmd_ok && (cmd == CMD_CALL);
    assign start_rti = cmd_ok && (cmd == CMD_RTI);
    assign start_rts = cmd_ok && (cmd == CMD_RTS);
    assign push_last = (state_reg == S_PUSH) && (cnt_reg == 3'h1);
    assign apply = (state_reg == S_WAIT) && (wait_reg == 2'h0);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (take_hw || start_swi || start_call) begin
                    state_next = S_PUSH;
                end else if (start_rti || start_rts) begin
                    state_next = S_PULL;
                end
            end
            S_PUSH: begin
                if (cnt_reg == 3'h1) begin
                    state_next = (kind_reg == K_CALL) ? S_IDLE : S_VEC;
                end
            end
            S_VEC, S_PULL: begin
                if (cnt_reg == 3'h1) begin
                    state_next = S_WAIT;
                end
            end
            S_WAIT: begin
                if (wait_reg == 2'h0) begin
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
        if (int_reset_req) begin
            state_next = S_VEC;
        end
    end

    // after reset the sequencer fetches the reset vector at once
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_VEC;
            busy_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            busy_reg <= (state_next != S_IDLE);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            kind_reg <= K_VEC;
            cnt_reg <= VEC_BYTES;
            wait_reg <= 2'h0;
            target_reg <= 16'h0000;
        end else begin
            if (int_reset_req) begin
                kind_reg <= K_VEC;
                cnt_reg <= VEC_BYTES;
            end else if (state_reg == S_IDLE) begin
                target_reg <= target_addr;
                if (take_hw) begin
                    kind_reg <= K_HW;
                    cnt_reg <= INT_BYTES;
                end else if (start_swi) begin
                    kind_reg <= K_SWI;
                    cnt_reg <= INT_BYTES;
                end else if (start_call) begin
                    kind_reg <= K_CALL;
                    cnt_reg <= CALL_BYTES;
                end else if (start_rti) begin
                    kind_reg <= K_RTI;
                    cnt_reg <= INT_BYTES;
                end else if (start_rts) begin
                    kind_reg <= K_RTS;
                    cnt_reg <= CALL_BYTES;
                end
            end else if (push_last) begin
                cnt_reg <= VEC_BYTES;
            end else if (cnt_reg != 3'h0) begin
                cnt_reg <= cnt_reg - 3'h1;
            end
            if ((state_reg == S_VEC || state_reg == S_PULL)
                && cnt_reg == 3'h1) begin
                wait_reg <= READ_LAT;
            end else if (wait_reg != 2'h0) begin
                wait_reg <= wait_reg - 2'h1;
            end
        end
    end

    // vector chosen at the trap command or on the last hardware push; reset wins, then hardware, then trap
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vec_reg <= VEC_RESET;
        end else if (int_reset_req) begin
            vec_reg <= VEC_RESET;
        end else if (start_swi && !take_hw) begin
            vec_reg <= VEC_SWI;
        end else if (push_last && kind_reg == K_HW) begin
            vec_reg <= ext_pending_reg ? VEC_EXT : VEC_TIMER;
        end
    end

    // set wins over the clear taken on entry to the external handler
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_pending_reg <= 1'b0;
        end else begin
            ext_pending_reg <= ext_req_set | (ext_pending_reg
                & ~(push_last && kind_reg == K_HW));
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sp_reg <= SP_RESET;
        end else if (int_reset_req || (cmd_ok && cmd == CMD_RSP)) begin
            sp_reg <= SP_RESET;
        end else if (state_reg == S_PUSH) begin
            sp_reg <= sp_reg - 6'h01;
        end else if (state_reg == S_PULL) begin
            sp_reg <= sp_inc;
        end
    end

    // low byte leaves first: pcl, pch, index, accumulator, flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            push_reg <= 40'h0000000000;
        end else if (take_hw || start_swi) begin
            push_reg <= {condition_flags_register, acc_in, idx_in,
                         prog_addr};
        end else if (start_call) begin
            push_reg <= {24'h000000, prog_addr};
        end else if (state_reg == S_PUSH) begin
            push_reg <= {8'h00, push_reg[39:8]};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            re_q1_reg <= 1'b0;
            rd_reg <= 40'h0000000000;
        end else begin
            re_q1_reg <= mem_re_reg;
            if (re_q1_reg) begin
                rd_reg <= {rd_reg[31:0], mem_rdata};
            end
        end
    end

    always_comb begin
        bus_addr = mem_addr_reg;
        bus_wdata = 8'h00;
        bus_we = 1'b0;
        bus_re = 1'b0;
        case (state_reg)
            S_PUSH: begin
                bus_addr = {STACK_PAGE, sp_reg};
                bus_wdata = push_reg[7:0];
                bus_we = 1'b1;
            end
            S_PULL: begin
                bus_addr = {STACK_PAGE, sp_inc};
                bus_re = 1'b1;
            end
            S_VEC: begin
                bus_addr = (cnt_reg == VEC_BYTES) ? vec_reg
                                                  : vec_reg + 16'h0001;
                bus_re = 1'b1;
            end
            default: begin
                bus_re = 1'b0;
            end
        endcase
    end

    assign map_bus.addr = bus_addr;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr_reg <= 16'h0000;
            mem_wdata_reg <= 8'h00;
            mem_we_reg <= 1'b0;
            mem_re_reg <= 1'b0;
            mem_region_reg <= RGN_NONE;
        end else begin
            mem_addr_reg <= bus_addr;
            mem_wdata_reg <= bus_wdata;
            mem_we_reg <= bus_we && !int_reset_req;
            mem_re_reg <= bus_re && !int_reset_req;
            mem_region_reg <= map_bus.region;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_reg <= 13'h0000;
        end else if (apply) begin
            pc_reg <= rd_reg[PC_W-1:0];
        end else if (push_last && kind_reg == K_CALL) begin
            pc_reg <= target_reg[PC_W-1:0];
        end else if (cmd_ok && cmd == CMD_JUMP) begin
            pc_reg <= target_addr[PC_W-1:0];
        end else if (cmd_ok && cmd == CMD_FETCH) begin
            pc_reg <= pc_reg + 13'h0001;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            restore_valid_reg <= 1'b0;
            acc_out_reg <= 8'h00;
            idx_out_reg <= 8'h00;
        end else begin
            restore_valid_reg <= apply && (kind_reg == K_RTI);
            if (apply && kind_reg == K_RTI) begin
                acc_out_reg <= rd_reg[31:24];
                idx_out_reg <= rd_reg[23:16];
            end
        end
    end

    always_comb begin
        cin = (alu_op == ALU_ADC || alu_op == ALU_SBC) && flags_reg[CCR_C];
        half5 = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, cin};
        sum9 = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, cin};
        alu_res = alu_a;
        alu_c = alu_cbit;
        alu_h = half5[4];
        upd_h = 1'b0;
        upd_c = 1'b1;
        upd_nz = 1'b1;
        case (alu_op)
            ALU_ADD, ALU_ADC: begin
                alu_res = sum9[7:0];
                alu_c = sum9[8];
                upd_h = 1'b1;
            end
            ALU_SUB, ALU_SBC: begin
                sum9 = {1'b0, alu_a} - {1'b0, alu_b} - {8'h00, cin};
                alu_res = sum9[7:0];
                alu_c = sum9[8];
            end
            ALU_LOGIC: upd_c = 1'b0;
            ALU_BTB: upd_nz = 1'b0;
            default: alu_c = alu_cbit;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_reg <= 5'h08;
            alu_result_reg <= 8'h00;
        end else if (int_reset_req) begin
            flags_reg[CCR_I] <= 1'b1;
        end else if (apply && kind_reg == K_RTI) begin
            flags_reg <= rd_reg[36:32];
        end else if (push_last && kind_reg != K_CALL) begin
            flags_reg[CCR_I] <= 1'b1;
        end else begin
            if (cmd_ok && cmd == CMD_SEI) begin
                flags_reg[CCR_I] <= 1'b1;
            end else if (cmd_ok && cmd == CMD_CLI) begin
                flags_reg[CCR_I] <= 1'b0;
            end
            if (alu_valid) begin
                alu_result_reg <= alu_res;
                if (upd_h) begin
                    flags_reg[CCR_H] <= alu_h;
                end
                if (upd_nz) begin
                    flags_reg[CCR_N] <= alu_res[7];
                    flags_reg[CCR_Z] <= (alu_res == 8'h00);
                end
                if (upd_c) begin
                    flags_reg[CCR_C] <= alu_c;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            eff_addr_reg <= 16'h0000;
        end else begin
            case (idx_mode)
                IDX_OFF8: eff_addr_reg <= {IDX_HIGH, idx_in}
                    + {IDX_HIGH, idx_offset[7:0]};
                IDX_OFF16: eff_addr_reg <= {IDX_HIGH, idx_in}
                    + idx_offset;
                default: eff_addr_reg <= {IDX_HIGH, idx_in};
            endcase
        end
    end

endmodule
`default_nettype wire

// [core/cis_pkg.sv]
// constants and types shared by the interrupt sequencer files
package cis_pkg;

    localparam int PC_W = 13;
    localparam logic [15:0] VEC_RESET = 16'h1FFE;
    localparam logic [15:0] VEC_SWI = 16'h1FFC;
    localparam logic [15:0] VEC_EXT = 16'h1FFA;
    localparam logic [15:0] VEC_TIMER = 16'h1FF8;
    localparam logic [5:0] SP_RESET = 6'h3F;
    localparam logic [9:0] STACK_PAGE = 10'h003;
    localparam logic [2:0] CCR_ONES = 3'h7;
    localparam logic [2:0] PC_UPPER = 3'h0;
    localparam logic [7:0] IDX_HIGH = 8'h00;
    localparam int CCR_H = 4;
    localparam int CCR_I = 3;
    localparam int CCR_N = 2;
    localparam int CCR_Z = 1;
    localparam int CCR_C = 0;
    localparam logic [2:0] CALL_BYTES = 3'h2;
    localparam logic [2:0] INT_BYTES = 3'h5;
    localparam logic [2:0] VEC_BYTES = 3'h2;
    localparam logic [1:0] READ_LAT = 2'h2;

    localparam logic [15:0] IO_LO = 16'h0000;
    localparam logic [15:0] IO_HI = 16'h001F;
    localparam logic [15:0] PAGE0_LO = 16'h0020;
    localparam logic [15:0] PAGE0_HI = 16'h004F;
    localparam logic [15:0] RAM_LO = 16'h0080;
    localparam logic [15:0] RAM_HI = 16'h00FF;
    localparam logic [15:0] ROM1_LO = 16'h0100;
    localparam logic [15:0] ROM1_HI = 16'h08FF;
    localparam logic [15:0] ROM2_LO = 16'h1F00;
    localparam logic [15:0] ROM2_HI = 16'h1FCF;
    localparam logic [15:0] TEST_LO = 16'h1FD0;
    localparam logic [15:0] TEST_HI = 16'h1FEF;
    localparam logic [15:0] VECT_LO = 16'h1FF0;
    localparam logic [15:0] VECT_HI = 16'h1FFF;

    typedef enum logic [3:0] {
        CMD_NONE, CMD_FETCH, CMD_JUMP, CMD_CALL, CMD_RTS,
        CMD_SWI, CMD_RTI, CMD_RSP, CMD_SEI, CMD_CLI
    } cis_cmd_t;

    typedef enum logic [2:0] {
        ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_LOGIC, ALU_SHIFT, ALU_BTB
    } cis_alu_t;

    typedef enum logic [1:0] {IDX_NONE, IDX_OFF8, IDX_OFF16} cis_idx_t;

    typedef enum logic [2:0] {
        RGN_NONE, RGN_IO, RGN_PAGE0, RGN_RAM, RGN_ROM, RGN_TEST, RGN_VECT
    } cis_region_t;

    typedef enum {S_IDLE, S_PUSH, S_VEC, S_PULL, S_WAIT} cis_state_t;

    typedef enum logic [2:0] {
        K_HW, K_SWI, K_CALL, K_VEC, K_RTI, K_RTS
    } cis_kind_t;

endpackage

// [core/cis_map_if.sv]
// address to memory region lookup between sequencer and decoder
`timescale 1ns/10ps
`default_nettype none
interface cis_map_if;
    import cis_pkg::*;
    logic [15:0] addr;
    cis_region_t region;
    modport requester (output addr, input region);
    modport decoder (input addr, output region);
endinterface
`default_nettype wire

// [core/cis_addr_map.sv]
// memory map decoder: io, page zero rom, ram, user rom, test, vectors
`timescale 1ns/10ps
`default_nettype none
module cis_addr_map
    import cis_pkg::*;
(
    cis_map_if.decoder map
);

    function automatic logic in_range(
        input logic [15:0] a,
        input logic [15:0] lo,
        input logic [15:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction

    always_comb begin
        map.region = RGN_NONE;
        if (in_range(map.addr, IO_LO, IO_HI)) begin
            map.region = RGN_IO;
        end else if (in_range(map.addr, PAGE0_LO, PAGE0_HI)) begin
            map.region = RGN_PAGE0;
        end else if (in_range(map.addr, RAM_LO, RAM_HI)) begin
            map.region = RGN_RAM;
        end else if (in_range(map.addr, ROM1_LO, ROM1_HI)
                     || in_range(map.addr, ROM2_LO, ROM2_HI)) begin
            map.region = RGN_ROM;
        end else if (in_range(map.addr, TEST_LO, TEST_HI)) begin
            map.region = RGN_TEST;
        end else if (in_range(map.addr, VECT_LO, VECT_HI)) begin
            map.region = RGN_VECT;
        end
    end

endmodule
`default_nettype wire

// [testbench/cis_seq_props.sv]
// port assertions for the interrupt sequencer
`timescale 1ns/10ps
`default_nettype none
module cis_seq_props
    import cis_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic int_reset_req,
    input wire logic alu_valid,
    input wire cis_alu_t alu_op,
    input wire cis_idx_t idx_mode,
    input wire logic [7:0] idx_in,
    input wire logic busy_reg,
    input wire logic [15:0] prog_addr,
    input wire logic [7:0] condition_flags_register,
    input wire logic [7:0] stack_addr,
    input wire logic [15:0] mem_addr_reg,
    input wire logic mem_we_reg,
    input wire logic mem_re_reg,
    input wire cis_region_t mem_region_reg,
    input wire logic [7:0] alu_result_reg,
    input wire logic [15:0] eff_addr_reg,
    input wire logic ext_pending_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence call_push_s;
        mem_we_reg [*2] ##1 !mem_we_reg;
    endsequence
    sequence entry_push_s;
        mem_we_reg [*5] ##1 !mem_we_reg;
    endsequence
    stack_page_a: assert property (stack_addr[7:6] == 2'h3)
        else $error("stack address outside window");
    pc_upper_a: assert property (prog_addr[15:13] == 3'h0)
        else $error("program address upper bits set");
    flag_ones_a: assert property (condition_flags_register[7:5] == 3'h7)
        else $error("flag upper bits not ones");
    push_page_a: assert property (mem_we_reg |->
        mem_addr_reg[15:6] == 10'h003 && mem_region_reg == RGN_RAM)
        else $error("stack write outside stack window");
    push_step_a: assert property (mem_we_reg && $past(mem_we_reg) |->
        mem_addr_reg[5:0] == $past(mem_addr_reg[5:0]) - 6'h01)
        else $error("stack write address not decremented");
    push_count_a: assert property ($rose(mem_we_reg) |->
        call_push_s or entry_push_s)
        else $error("push burst length wrong");
    reset_vec_a: assert property ($rose(reset_n) |->
        condition_flags_register[3] ##[0:3]
        (mem_re_reg && mem_addr_reg == 16'h1FFE))
        else $error("reset vector not fetched");
    vec_pair_a: assert property (mem_re_reg &&
        mem_addr_reg[15:4] == 12'h1FF && !mem_addr_reg[0] |->
        mem_region_reg == RGN_VECT ##1 (mem_re_reg && mem_addr_reg[0]))
        else $error("vector byte pair broken");
    held_req_a: assert property (ext_pending_reg && !busy_reg &&
        condition_flags_register[3] && !int_reset_req |=> ext_pending_reg)
        else $error("masked request lost");
    idx_zero_a: assert property (idx_mode == IDX_NONE |=>
        eff_addr_reg == {8'h00, $past(idx_in)})
        else $error("indexed address wrong");
    alu_nz_a: assert property (alu_valid && !busy_reg && !int_reset_req &&
        alu_op inside {ALU_ADD, ALU_SUB} |=>
        condition_flags_register[1] == (alu_result_reg == 8'h00) &&
        condition_flags_register[2] == alu_result_reg[7])
        else $error("zero or negative flag wrong");
endmodule
bind cis_sequencer cis_seq_props i_props (.clk, .reset_n, .int_reset_req,
    .alu_valid, .alu_op, .idx_mode, .idx_in, .busy_reg, .prog_addr,
    .condition_flags_register, .stack_addr, .mem_addr_reg, .mem_we_reg,
    .mem_re_reg, .mem_region_reg, .alu_result_reg, .eff_addr_reg,
    .ext_pending_reg);
`default_nettype wire

// [testbench/cis_far_model.sv]
// memory and timer request source model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module cis_far_model
(
    input wire logic clk,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic mem_re,
    input wire logic [2:0] tmr_set,
    input wire logic [2:0] tmr_clr,
    output logic [7:0] mem_rdata,
    output logic [2:0] tmr_flags
);
    logic [7:0] ram [256];
    initial mem_rdata = 8'h00;
    initial tmr_flags = 3'h0;
    // rom bytes repeat the low address nibble; idle data keeps toggling
    always @(posedge clk) begin
        if (mem_we)
            ram[mem_addr[7:0]] <= mem_wdata;
        if (!mem_re)
            mem_rdata <= ~mem_rdata;
        else if (mem_addr[15:8] == 8'h00)
            mem_rdata <= ram[mem_addr[7:0]];
        else
            mem_rdata <= {mem_addr[3:0], mem_addr[3:0]};
        tmr_flags <= (tmr_flags | tmr_set) & ~tmr_clr;
    end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the interrupt sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import cis_pkg::*;
    logic clk, reset_n, int_reset_req, cmd_valid, instr_done, ext_req_set;
    logic capture_int_enable, compare_int_enable, overflow_int_enable;
    logic alu_valid, alu_cbit, busy_reg, mem_we_reg, mem_re_reg;
    logic restore_valid_reg, ext_pending_reg;
    cis_cmd_t cmd;
    cis_alu_t alu_op;
    cis_idx_t idx_mode;
    cis_region_t mem_region_reg;
    logic [15:0] target_addr, idx_offset, prog_addr, mem_addr_reg;
    logic [15:0] eff_addr_reg;
    logic [7:0] alu_a, alu_b, acc_in, idx_in, mem_rdata, stack_addr;
    logic [7:0] condition_flags_register, mem_wdata_reg, alu_result_reg;
    logic [7:0] acc_out_reg, idx_out_reg;
    logic [2:0] tmr_set, tmr_clr, tmr_flags;
    int fail_count = 0;
    int checks_done = 0;
    cis_sequencer i_dut (.clk, .reset_n, .int_reset_req, .cmd_valid, .cmd,
        .target_addr, .instr_done, .ext_req_set,
        .capture_flag(tmr_flags[0]), .compare_flag(tmr_flags[1]),
        .overflow_flag(tmr_flags[2]), .capture_int_enable,
        .compare_int_enable, .overflow_int_enable, .alu_valid, .alu_op,
        .alu_a, .alu_b, .alu_cbit, .acc_in, .idx_in, .idx_mode, .idx_offset,
        .mem_rdata, .busy_reg, .prog_addr, .condition_flags_register,
        .stack_addr, .mem_addr_reg, .mem_wdata_reg, .mem_we_reg, .mem_re_reg,
        .mem_region_reg, .alu_result_reg, .eff_addr_reg, .restore_valid_reg,
        .acc_out_reg, .idx_out_reg, .ext_pending_reg);
    cis_far_model i_far (.clk, .mem_addr(mem_addr_reg),
        .mem_wdata(mem_wdata_reg), .mem_we(mem_we_reg), .mem_re(mem_re_reg),
        .tmr_set, .tmr_clr, .mem_rdata, .tmr_flags);
    always #10 clk = ~clk;
    task automatic conclude();
        $display("fail_count %0d checks_done %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t %s %h/%h", $time, m, got, exp);
        end
    endtask
    task automatic idle();
        repeat (2) @(negedge clk);
        for (int i = 0; i < 60 && busy_reg !== 1'b0; i++)
            @(negedge clk);
        chk(busy_reg, 16'h0, "stuck busy");
    endtask
    task automatic go(input cis_cmd_t c, input logic [15:0] t);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd = c;
        target_addr = t;
        @(negedge clk);
        cmd_valid = 1'b0;
        idle();
    endtask
    task automatic pulse(input logic ed, ex, input logic [2:0] ts, tc);
        @(negedge clk);
        {instr_done, ext_req_set, tmr_set, tmr_clr} = {ed, ex, ts, tc};
        @(negedge clk);
        {instr_done, ext_req_set, tmr_set, tmr_clr} = 8'h00;
        idle();
    endtask
    task automatic alu(input cis_alu_t op, input logic [7:0] a, b, r, f);
        @(negedge clk);
        alu_op = op;
        {alu_valid, alu_a, alu_b} = {1'b1, a, b};
        @(negedge clk);
        alu_valid = 1'b0;
        chk(alu_result_reg, r, "alu result");
        chk(condition_flags_register, f, "alu flags");
    endtask
    task automatic t_alu();
        alu(ALU_ADD, 8'h0F, 8'h01, 8'h10, 8'hF8);
        alu(ALU_ADD, 8'h80, 8'h80, 8'h00, 8'hEB);
        alu(ALU_ADC, 8'h07, 8'h08, 8'h10, 8'hF8);
        alu(ALU_SUB, 8'h00, 8'h01, 8'hFF, 8'hFD);
        alu(ALU_LOGIC, 8'h00, 8'h00, 8'h00, 8'hFB);
    endtask
    task automatic t_hw();
        pulse(1'b1, 1'b1, 3'h0, 3'h0);
        chk(prog_addr, 16'h0F00, "masked taken");
        chk(ext_pending_reg, 16'h1, "latch lost");
        go(CMD_CLI, 16'h0000);
        pulse(1'b1, 1'b0, 3'h0, 3'h0);
        chk(prog_addr, 16'h0ABB, "ext vector");
        chk(stack_addr, 16'hFA, "entry push");
        chk(condition_flags_register[3], 16'h1, "mask");
        chk(ext_pending_reg, 16'h0, "latch kept");
        go(CMD_RTI, 16'h0000);
        chk(prog_addr, 16'h0F00, "resume");
        chk({acc_out_reg, idx_out_reg}, 16'h3CC3, "restore");
        chk(restore_valid_reg, 16'h1, "strobe");
        chk(condition_flags_register[3], 16'h0, "mask back");
    endtask
    task automatic t_timer();
        pulse(1'b1, 1'b0, 3'h1, 3'h0);
        chk(prog_addr, 16'h0F00, "disabled taken");
        capture_int_enable = 1'b1;
        pulse(1'b1, 1'b0, 3'h0, 3'h0);
        chk(prog_addr, 16'h0899, "timer vector");
        pulse(1'b0, 1'b0, 3'h0, 3'h7);
        go(CMD_RTI, 16'h0000);
        overflow_int_enable = 1'b1;
        pulse(1'b0, 1'b1, 3'h4, 3'h0);
        pulse(1'b1, 1'b0, 3'h0, 3'h0);
        chk(prog_addr, 16'h0ABB, "priority");
        go(CMD_RTI, 16'h0000);
        pulse(1'b1, 1'b0, 3'h0, 3'h0);
        chk(prog_addr, 16'h0899, "second served");
        pulse(1'b0, 1'b0, 3'h0, 3'h7);
        go(CMD_RTI, 16'h0000);
    endtask
    task automatic t_stack();
        go(CMD_CALL, 16'h0200);
        chk({stack_addr, prog_addr[11:4]}, 16'hFD20, "call");
        go(CMD_RTS, 16'h0000);
        chk({stack_addr, prog_addr[11:4]}, 16'hFFF0, "return");
        go(CMD_SEI, 16'h0000);
        go(CMD_SWI, 16'h0000);
        chk({stack_addr, prog_addr}, 24'hFA0CDD, "trap");
        for (int i = 0; i < 33; i++)
            go(CMD_CALL, 16'h0300);
        chk(stack_addr, 16'hF8, "wrap");
        go(CMD_RSP, 16'h0000);
        chk(stack_addr, 16'hFF, "reinit");
    endtask
    task automatic t_misc();
        idx_mode = IDX_OFF8;
        {idx_in, idx_offset} = {8'hF0, 16'h0020};
        @(negedge clk);
        chk(eff_addr_reg, 16'h0110, "offset8");
        idx_mode = IDX_OFF16;
        {idx_in, idx_offset} = {8'hFF, 16'h1F00};
        @(negedge clk);
        chk(eff_addr_reg, 16'h1FFF, "offset16");
        go(CMD_JUMP, 16'hE123);
        chk(prog_addr, 16'h0123, "jump");
        go(CMD_CLI, 16'h0000);
        go(CMD_CALL, 16'h0400);
        @(negedge clk);
        int_reset_req = 1'b1;
        @(negedge clk);
        int_reset_req = 1'b0;
        idle();
        chk({stack_addr, prog_addr}, 24'hFF0EFF, "int reset");
        chk(condition_flags_register, 16'hFB, "int reset mask");
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        conclude();
    end
    initial begin
        {clk, reset_n, int_reset_req, cmd_valid, instr_done} = 5'h00;
        {ext_req_set, alu_valid, alu_cbit, tmr_set, tmr_clr} = 9'h000;
        {capture_int_enable, compare_int_enable, overflow_int_enable} = 3'h0;
        cmd = CMD_NONE;
        alu_op = ALU_ADD;
        idx_mode = IDX_NONE;
        {target_addr, idx_offset, alu_a, alu_b} = 48'h0;
        {acc_in, idx_in} = 16'h3CC3;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        idle();
        chk(prog_addr, 16'h0EFF, "reset vector");
        chk({condition_flags_register, stack_addr}, 16'hE8FF, "reset");
        go(CMD_FETCH, 16'h0000);
        chk(prog_addr, 16'h0F00, "fetch");
        t_alu();
        t_hw();
        t_timer();
        t_stack();
        t_misc();
        conclude();
    end
endmodule
`default_nettype wire
